// ---- design/pcoc_pkg.sv ----
// Constants, codes and helpers shared by the PLL chain output clocking block.
// Assumes a 100 MHz core clock and a byte-wide register port.
`default_nettype none
package pcoc_pkg;
   // ********************************************************************
   // Register map
   // ********************************************************************
   localparam logic [7:0] ADDR_X_MODE = 8'h05;
   localparam logic [7:0] ADDR_Y_MODE = 8'h06;
   localparam logic [7:0] ADDR_PPS_LO = 8'hA0;
   localparam logic [7:0] ADDR_PPS_HI = 8'hA1;
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [11:0] PPS_WIDTH_RST = 12'h00A;

   // ********************************************************************
   // Timing
   // ********************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int US_IN_NS = 1000;
   localparam int CYC_PER_US = US_IN_NS / CLK_PERIOD_NS;
   localparam logic [6:0] SUB_LAST = 7'(CYC_PER_US - 1);

   // ********************************************************************
   // Widths, limits and codes
   // ********************************************************************
   localparam int NPORT = 8;
   localparam int DIV_W = 20;
   localparam int S1_CFG_W = 32;
   localparam int S2_CFG_W = 32;
   localparam logic [13:0] SYNTH_M_MIN = 14'h04E2;
   localparam logic [13:0] SYNTH_M_MAX = 14'h2710;

   typedef enum logic [2:0] {
      PCOC_MODE_OFF = 3'b000,
      PCOC_MODE_SE_S2 = 3'b001,
      PCOC_MODE_DIFF_S2 = 3'b010,
      PCOC_MODE_SE_ONLY = 3'b011,
      PCOC_MODE_DIFF_ONLY = 3'b100
   } pcoc_mode_t;

   typedef enum logic [1:0] {
      PCOC_FMT_CMOS = 2'b00,
      PCOC_FMT_LVDS = 2'b01,
      PCOC_FMT_LVPECL = 2'b10,
      PCOC_FMT_OFF = 2'b11
   } pcoc_fmt_t;

   // Source codes: index into the four stage clocks.
   localparam logic [1:0] SRC_X1 = 2'h0;
   localparam logic [1:0] SRC_X2 = 2'h1;
   localparam logic [1:0] SRC_Y1 = 2'h2;
   localparam logic [1:0] SRC_Y2 = 2'h3;

   typedef enum logic [1:0] {
      PCOC_CH_IDLE = 2'b00,
      PCOC_CH_CAL = 2'b01,
      PCOC_CH_RUN = 2'b10
   } pcoc_chain_t;

   // Decode a chain mode into {stage1 on, stage2 on, differential VCXO}.
   // The Y chain has no differential input, so codes 2 and 4 act as 1 and 3.
   function automatic logic [2:0] pcoc_decode(input logic [2:0] mode,
                                              input logic is_y);
      logic [2:0] r;
      r = 3'b000;
      case (mode)
         PCOC_MODE_SE_S2: r = 3'b110;
         PCOC_MODE_DIFF_S2: r = is_y ? 3'b110 : 3'b111;
         PCOC_MODE_SE_ONLY: r = 3'b100;
         PCOC_MODE_DIFF_ONLY: r = is_y ? 3'b100 : 3'b101;
         default: r = 3'b000;
      endcase
      return r;
   endfunction : pcoc_decode
endpackage : pcoc_pkg
`default_nettype wire

// ---- design/pcoc_top.sv ----
// Digital control around the X and Y PLL chains, port dividers and 1PPS.
// Assumes stage clocks arrive asynchronously and are slow against core_clk_i;
// the timing generator tick is on the core clock.
//
// What this block and its host do
// R1: X mode 0,5,6,7 off; 1/2 SE/diff to stage two; 3/4 stage two off.
// R2: Y mode 0,5,6,7 off; 1,2 SE to stage two; 3,4 stage two off.
// R3: Ports one to eight each have a 20-bit divider, ratio 1 to 1048576.
// R4: Dividers behave the same for stage-one or stage-two source clocks.
// R5: Ports 1-8 pick any stage of X or Y; port 0 X, port 10 Y.
// R6: Each transmitter emits two CMOS, one LVDS or one LVPECL signal.
// R7: Unused transmitters can be powered down by configuration.
// R8: CMOS mode drives both pins or one, each pin polarity selectable.
// R9: Output eleven is 8 kHz times M, M limited to 1250..10000.
// R10: Host sets stage-one detector rate as 8 kHz times at most 5000.
// R11: Stage-one pump current, feedback divider, two resistors are settings.
// R12: Stage-two settings exposed; updates accepted while running after lock.
// R13: Host loads all chain settings before writing the chain mode.
// R14: Writing a chain mode that uses stage two starts self-calibration with loaded settings; a rewrite mid-calibration keeps the earlier settings.
// R15: Host should use stage-two pre-divider above 180 MHz oscillator.
// R16: A once-per-second pulse with programmable width is generated.
// R17: Pulse width is 12 bits in microseconds, default ten.
// R18: Ratio N gives one output period per N inputs; N=1 passes through.
`default_nettype none
module pcoc_top
   import pcoc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [3:0] stage_clk_i,
   input wire logic [1:0] cal_done_i,
   input wire logic [NPORT*DIV_W-1:0] div_ratio_i,
   input wire logic [NPORT*2-1:0] port_src_i,
   input wire logic [NPORT*2-1:0] port_fmt_i,
   input wire logic [NPORT*2-1:0] cmos_pin_en_i,
   input wire logic [NPORT*2-1:0] cmos_pol_i,
   input wire logic [2*S1_CFG_W-1:0] s1_cfg_i,
   input wire logic [2*S2_CFG_W-1:0] s2_cfg_i,
   input wire logic [13:0] synth_mult_i,
   input wire logic pps_tick_i,
   output logic [1:0] s1_pwr_o,
   output logic [1:0] s2_pwr_o,
   output logic x_vcxo_diff_o,
   output logic [1:0] cal_start_o,
   output logic [1:0] chain_locked_o,
   output logic [2*S1_CFG_W-1:0] s1_cfg_o,
   output logic [2*S2_CFG_W-1:0] s2_cfg_o,
   output logic [NPORT-1:0] tx_pwr_o,
   output logic [NPORT*2-1:0] tx_fmt_o,
   output logic [NPORT-1:0] port_p_o,
   output logic [NPORT-1:0] port_n_o,
   output logic port0_o,
   output logic port10_o,
   output logic [13:0] synth_mult_o,
   output logic pps_o
);
   // ********************************************************************
   // Registers and decode
   // ********************************************************************
   logic [2:0] mode [2];
   logic [11:0] pps_width;
   logic [2:0] dec_x, dec_y;
   logic wr_x, wr_y;

   assign wr_x = reg_wr_i && (reg_addr_i == ADDR_X_MODE);
   assign wr_y = reg_wr_i && (reg_addr_i == ADDR_Y_MODE);
   assign dec_x = pcoc_decode(mode[0], 1'b0); // see R1
   assign dec_y = pcoc_decode(mode[1], 1'b1); // see R2
   assign s1_pwr_o = {dec_y[2], dec_x[2]};
   assign s2_pwr_o = {dec_y[1], dec_x[1]};
   assign x_vcxo_diff_o = dec_x[0];

   // Host writes; the width spans two byte addresses.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mode <= '{default: MODE_RST};
         pps_width <= PPS_WIDTH_RST; // see R17
      end else begin
         if (wr_x) mode[0] <= reg_wdata_i[2:0];
         if (wr_y) mode[1] <= reg_wdata_i[2:0];
         if (reg_wr_i && reg_addr_i == ADDR_PPS_LO)
            pps_width[7:0] <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == ADDR_PPS_HI)
            pps_width[11:8] <= reg_wdata_i[3:0];
      end
   end

   // Read mux; unmapped addresses read as zero.
   assign reg_rdata_o =
      (reg_addr_i == ADDR_X_MODE) ? {5'h00, mode[0]} :
      (reg_addr_i == ADDR_Y_MODE) ? {5'h00, mode[1]} :
      (reg_addr_i == ADDR_PPS_LO) ? pps_width[7:0] :
      (reg_addr_i == ADDR_PPS_HI) ? {4'h0, pps_width[11:8]} : 8'h00;

   // ********************************************************************
   // Synchronisers for analog-side signals
   // ********************************************************************
   logic [3:0] clk_m, clk_s, clk_d, clk_rise;
   logic [1:0] done_m, done_s;
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         {clk_m, clk_s, clk_d} <= '0;
         {done_m, done_s} <= '0;
      end else begin
         clk_m <= stage_clk_i;
         clk_s <= clk_m;
         clk_d <= clk_s;
         done_m <= cal_done_i;
         done_s <= done_m;
      end
   end
   assign clk_rise = clk_s & ~clk_d;

   // ********************************************************************
   // Chain calibration sequencing
   // ********************************************************************
   // A mode write restarts the chain even mid-calibration, since the
   // host has just changed what the analog side must lock to.
   pcoc_chain_t st [2];
   logic [1:0] mode_wr, use_s2, use_s1;
   logic [2:0] wr_dec_x, wr_dec_y;
   assign mode_wr = {wr_y, wr_x};
   // Decode the byte being written, so the start pulse matches the new mode.
   assign wr_dec_x = pcoc_decode(reg_wdata_i[2:0], 1'b0);
   assign wr_dec_y = pcoc_decode(reg_wdata_i[2:0], 1'b1);
   assign use_s2 = {wr_dec_y[1], wr_dec_x[1]};
   assign use_s1 = {dec_y[2], dec_x[2]};
   always_ff @(posedge core_clk_i) begin
      for (int c = 0; c < 2; c++) begin
         if (rst_i) begin
            st[c] <= PCOC_CH_IDLE;
            cal_start_o[c] <= 1'b0;
         end else begin
            cal_start_o[c] <= mode_wr[c] && use_s2[c]; // see R14
            if (mode_wr[c]) begin
               st[c] <= use_s2[c] ? PCOC_CH_CAL : PCOC_CH_RUN; // see R14
            end else begin
               case (st[c])
                  PCOC_CH_CAL: if (done_s[c]) st[c] <= PCOC_CH_RUN;
                  PCOC_CH_RUN: if (!use_s1[c]) st[c] <= PCOC_CH_IDLE;
                  default: st[c] <= PCOC_CH_IDLE;
               endcase
            end
         end
      end
   end
   assign chain_locked_o = {st[1] == PCOC_CH_RUN && use_s1[1],
                            st[0] == PCOC_CH_RUN && use_s1[0]};

   // Stage settings; stage two is frozen only while calibrating, so the
   // calibration sees the values loaded before the write that entered it; a rewrite mid-calibration does not reload them.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         {s1_cfg_o, s2_cfg_o} <= '0;
      end else begin
         s1_cfg_o <= s1_cfg_i; // see R11
         for (int c = 0; c < 2; c++)
            if (st[c] != PCOC_CH_CAL)
               s2_cfg_o[c*S2_CFG_W +: S2_CFG_W] <=
                  s2_cfg_i[c*S2_CFG_W +: S2_CFG_W]; // see R12
      end
   end
   // ********************************************************************
   // Port dividers and transmitters
   // ********************************************************************
   logic [DIV_W-1:0] cnt [NPORT];
   logic [NPORT-1:0] div_q;

   // Counting source edges keeps the divider blind to which stage feeds it.
   always_ff @(posedge core_clk_i) begin
      for (int p = 0; p < NPORT; p++) begin
         if (rst_i) begin
            cnt[p] <= '0;
            div_q[p] <= 1'b0;
         end else begin
            if (clk_rise[port_src_i[2*p +: 2]]) // see R4 R5
               cnt[p] <= (cnt[p] >= div_ratio_i[p*DIV_W +: DIV_W]) ?
                         '0 : cnt[p] + 1'b1; // see R3 R18
            if (div_ratio_i[p*DIV_W +: DIV_W] == '0)
               div_q[p] <= clk_s[port_src_i[2*p +: 2]]; // see R18
            else
               div_q[p] <= {1'b0, cnt[p]} <
                  (({1'b0, div_ratio_i[p*DIV_W +: DIV_W]} + 21'h1) >> 1);
         end
      end
   end
   always_ff @(posedge core_clk_i) begin
      for (int p = 0; p < NPORT; p++) begin
         if (rst_i) begin
            port_p_o[p] <= 1'b0;
            port_n_o[p] <= 1'b0;
         end else begin
            case (port_fmt_i[2*p +: 2])
               PCOC_FMT_CMOS: begin // see R8
                  port_p_o[p] <= cmos_pin_en_i[2*p] &
                                 (div_q[p] ^ cmos_pol_i[2*p]);
                  port_n_o[p] <= cmos_pin_en_i[2*p+1] &
                                 (div_q[p] ^ cmos_pol_i[2*p+1]);
               end
               PCOC_FMT_LVDS, PCOC_FMT_LVPECL: begin // see R6
                  port_p_o[p] <= div_q[p];
                  port_n_o[p] <= ~div_q[p];
               end
               default: begin // see R7
                  port_p_o[p] <= 1'b0;
                  port_n_o[p] <= 1'b0;
               end
            endcase
         end
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         {tx_pwr_o, tx_fmt_o, port0_o, port10_o} <= '0;
         synth_mult_o <= SYNTH_M_MIN;
      end else begin
         for (int p = 0; p < NPORT; p++)
            tx_pwr_o[p] <= port_fmt_i[2*p +: 2] != PCOC_FMT_OFF; // see R7
         tx_fmt_o <= port_fmt_i; // see R6
         port0_o <= dec_x[1] ? clk_s[SRC_X2] : clk_s[SRC_X1]; // see R5
         port10_o <= dec_y[1] ? clk_s[SRC_Y2] : clk_s[SRC_Y1]; // see R5
         // Out-of-range multipliers clamp rather than wrap. // see R9
         synth_mult_o <= (synth_mult_i < SYNTH_M_MIN) ? SYNTH_M_MIN :
                         (synth_mult_i > SYNTH_M_MAX) ? SYNTH_M_MAX :
                         synth_mult_i;
      end
   end

   // ********************************************************************
   // Once-per-second pulse
   // ********************************************************************
   logic [11:0] us_left;
   logic [6:0] sub;

   // A zero width suppresses the pulse instead of holding it high.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         {pps_o, us_left, sub} <= '0;
      end else if (pps_tick_i && pps_width != 12'h000) begin
         pps_o <= 1'b1; // see R16
         us_left <= pps_width;
         sub <= SUB_LAST;
      end else if (pps_o) begin
         sub <= (sub == 7'h00) ? SUB_LAST : sub - 7'h01;
         if (sub == 7'h00) begin
            us_left <= us_left - 12'h001;
            if (us_left == 12'h001) pps_o <= 1'b0; // see R17
         end
      end
   end

   // ********************************************************************
   // Assertions
   // ********************************************************************
   // One clock and one reset serve every check below.
   default clocking chk_clk @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_x_write_s2;
      wr_x && use_s2[0];
   endsequence
   sequence s_x_cal_held;
      st[0] == PCOC_CH_CAL ##1 st[0] == PCOC_CH_CAL;
   endsequence
   a_x_mode_decode: assert property (mode[0] == 3'h4 |-> // see R1
      s1_pwr_o[0] && !s2_pwr_o[0] && x_vcxo_diff_o)
      else $error("X mode 4 decode wrong");
   a_y_mode_decode: assert property (mode[1] == 3'h2 |-> // see R2
      s1_pwr_o[1] && s2_pwr_o[1])
      else $error("Y mode 2 decode wrong");
   a_cal_start: assert property (s_x_write_s2 |=> // see R14
      cal_start_o[0] && st[0] == PCOC_CH_CAL)
      else $error("calibration not started on mode write");
   a_cal_freeze: assert property (s_x_cal_held |-> // see R12
      $stable(s2_cfg_o[S2_CFG_W-1:0]))
      else $error("stage two settings moved during calibration");
   a_div_wrap: assert property (clk_rise[port_src_i[1:0]] && // see R3
      cnt[0] == div_ratio_i[DIV_W-1:0] |=> cnt[0] == '0)
      else $error("divider did not wrap at ratio");
   a_tx_off: assert property (port_fmt_i[1:0] == PCOC_FMT_OFF |=> // see R7
      !port_p_o[0] && !port_n_o[0] && !tx_pwr_o[0])
      else $error("powered-down transmitter still active");
   a_synth_range: assert property (##1 // see R9
      synth_mult_o >= SYNTH_M_MIN && synth_mult_o <= SYNTH_M_MAX)
      else $error("synth multiplier out of range");
   a_pps_start: assert property ($rose(pps_o) |-> // see R16
      $past(pps_tick_i) && us_left == $past(pps_width))
      else $error("pulse started without tick");
   a_pps_end: assert property ($fell(pps_o) |-> // see R17
      $past(us_left) == 12'h001 && $past(sub) == 7'h00)
      else $error("pulse ended at wrong length");
endmodule : pcoc_top
`default_nettype wire

// ---- tb/pcoc_vcxo_model.sv ----
// Behavioural stand-in for the external VCXOs and the stage-two calibrator.
// Assumes the core clock drives it; stage clocks are slow against it.
`default_nettype none
module pcoc_vcxo_model (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [1:0] s1_pwr_i,
   input wire logic [1:0] s2_pwr_i,
   input wire logic [1:0] cal_start_i,
   input wire logic [7:0] cal_delay_i,
   output logic [3:0] stage_clk_o,
   output logic [1:0] cal_done_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Distinct half periods let the bench tell the four sources apart.
   localparam int HALF [4] = '{7, 3, 11, 5};
   int cnt [4];
   int cal_cnt [2];
   // An unpowered oscillator is held low, as a stopped one would be.
   always_ff @(posedge core_clk_i) begin
      for (int i = 0; i < 4; i++) begin
         if (rst_i || !(i[0] ? s2_pwr_i[i/2] : s1_pwr_i[i/2])) begin
            cnt[i] <= 0;
            stage_clk_o[i] <= 1'b0;
         end else if (cnt[i] >= HALF[i] - 1) begin
            cnt[i] <= 0;
            stage_clk_o[i] <= !stage_clk_o[i];
         end else begin
            cnt[i] <= cnt[i] + 1;
         end
      end
   end
   // Calibration reports done after a delay the bench chooses per start.
   always_ff @(posedge core_clk_i) begin
      for (int c = 0; c < 2; c++) begin
         if (rst_i || !s2_pwr_i[c] || cal_start_i[c]) begin
            cal_done_o[c] <= 1'b0;
            cal_cnt[c] <= int'(cal_delay_i);
         end else if (cal_cnt[c] > 0) begin
            cal_cnt[c] <= cal_cnt[c] - 1;
         end else begin
            cal_done_o[c] <= 1'b1;
         end
      end
   end
endmodule : pcoc_vcxo_model
`default_nettype wire

// ---- tb/test_pcoc_top.sv ----
// Self-checking bench for the PLL chain output clocking block.
// Assumes the design package and the VCXO model are compiled before it.
`default_nettype none
module test_pcoc_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pcoc_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic [NPORT*DIV_W-1:0] div_ratio = '0;
   logic [15:0] port_src = '0;
   logic [15:0] port_fmt = '0;
   logic [15:0] pin_en = '0;
   logic [15:0] pol = '0;
   logic [63:0] s1_cfg = '0;
   logic [63:0] s2_cfg = '0;
   logic [13:0] synth_m = 14'h0000;
   logic pps_tick = 1'b0;
   logic [7:0] cal_delay = 8'h05;
   logic [7:0] rdata;
   logic [1:0] s1_pwr, s2_pwr, cal_start, locked, cal_done;
   logic x_diff, port0, port10, pps;
   logic [3:0] stage_clk;
   logic [63:0] s1_q, s2_q;
   logic [7:0] tx_pwr, port_p, port_n;
   logic [15:0] tx_fmt;
   logic [13:0] synth_q;
   int mismatches = 0;
   int checks_done = 0;
   int cyc = 0;
   pcoc_top pcoc_top_i (.core_clk_i(core_clk), .rst_i(rst),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
      .reg_rdata_o(rdata), .stage_clk_i(stage_clk), .cal_done_i(cal_done),
      .div_ratio_i(div_ratio), .port_src_i(port_src), .port_fmt_i(port_fmt),
      .cmos_pin_en_i(pin_en), .cmos_pol_i(pol), .s1_cfg_i(s1_cfg),
      .s2_cfg_i(s2_cfg), .synth_mult_i(synth_m), .pps_tick_i(pps_tick),
      .s1_pwr_o(s1_pwr), .s2_pwr_o(s2_pwr), .x_vcxo_diff_o(x_diff),
      .cal_start_o(cal_start), .chain_locked_o(locked), .s1_cfg_o(s1_q),
      .s2_cfg_o(s2_q), .tx_pwr_o(tx_pwr), .tx_fmt_o(tx_fmt),
      .port_p_o(port_p), .port_n_o(port_n), .port0_o(port0),
      .port10_o(port10), .synth_mult_o(synth_q), .pps_o(pps));
   pcoc_vcxo_model pcoc_vcxo_model_i (.core_clk_i(core_clk), .rst_i(rst),
      .s1_pwr_i(s1_pwr), .s2_pwr_i(s2_pwr), .cal_start_i(cal_start),
      .cal_delay_i(cal_delay), .stage_clk_o(stage_clk),
      .cal_done_o(cal_done));
   // ****************************************************************
   // Clock, watchdog and shared tasks
   // ****************************************************************
   // The clock runs at 100 MHz.
   initial begin
      forever #5 core_clk = !core_clk;
   end
   // A hang past the ceiling counts as a mismatch and ends the run.
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk
   // Writes take effect at the sampling edge; the task returns just after.
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge core_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge core_clk);
      #1;
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(string nm, logic [7:0] a, logic [7:0] exp);
      @(posedge core_clk);
      #1;
      reg_addr = a;
      #1;
      chk(nm, rdata, exp);
   endtask : rd
   task automatic step(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step
   // Expected {stage one on, stage two on, differential} for a mode code.
   function automatic logic [2:0] exp_mode(logic [2:0] m, logic y);
      case (m)
         3'h1: return 3'b110;
         3'h2: return y ? 3'b110 : 3'b111;
         3'h3: return 3'b100;
         3'h4: return y ? 3'b100 : 3'b101;
         default: return 3'b000;
      endcase
   endfunction : exp_mode
   function automatic logic [13:0] clamp(logic [13:0] m);
      return m < SYNTH_M_MIN ? SYNTH_M_MIN :
         (m > SYNTH_M_MAX ? SYNTH_M_MAX : m);
   endfunction : clamp
   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      logic [2:0] e;
      logic [21:0] pv, cv;
      int rs [22];
      int n [8];
      logic [13:0] mv [7];
      void'($urandom(32'h9a49f125));
      step(20);
      rst = 1'b0;
      rd("x_mode_rst", ADDR_X_MODE, 8'h00);
      rd("y_mode_rst", ADDR_Y_MODE, 8'h00);
      rd("width_lo_rst", ADDR_PPS_LO, 8'h0A);
      rd("width_hi_rst", ADDR_PPS_HI, 8'h00);
      rd("unmapped", 8'h33, 8'h00);
      chk("synth_rst", synth_q, SYNTH_M_MIN);
      $display("test reset done");
      // Settings are loaded before any mode write; the words are opaque
      // here, so detector rate and pre-divider choice live inside them.
      s1_cfg = {$urandom, $urandom};
      s2_cfg = {$urandom, $urandom};
      for (int m = 0; m < 8; m++) begin
         for (int y = 0; y < 2; y++) begin
            cal_delay = 8'($urandom_range(1, 40));
            wr(y ? ADDR_Y_MODE : ADDR_X_MODE, 8'(m) | 8'hF8);
            e = exp_mode(3'(m), y[0]);
            chk("s1_pwr", s1_pwr[y], e[2]);
            chk("s2_pwr", s2_pwr[y], e[1]);
            chk("cal_start", cal_start[y], e[1]);
            if (y == 0) chk("vcxo_diff", x_diff, e[0]);
            chk("mode_rd", rdata, 8'(m));
         end
      end
      $display("test mode decode done");
      cal_delay = 8'd60;
      wr(ADDR_X_MODE, 8'h01);
      wr(ADDR_Y_MODE, 8'h02);
      for (int i = 0; i < 300 && locked !== 2'b11; i++) step(1);
      chk("locked", locked, 2'b11);
      s1_cfg = {$urandom, $urandom};
      s2_cfg = {$urandom, $urandom};
      step(3);
      chk("s1_cfg", s1_q, s1_cfg);
      chk("s2_cfg", s2_q, s2_cfg);
      $display("test lock and settings done");
      // Port 0 gets ratio 1, ports 1..6 small random ratios; port 7 the largest ratio.
      for (int p = 0; p < 8; p++) begin
         n[p] = (p == 7) ? 1048576 : (p == 0 ? 1 : $urandom_range(1, 6));
         div_ratio[p*DIV_W +: DIV_W] = 20'(n[p] - 1);
         port_src[2*p +: 2] = 2'($urandom);
         pol[2*p +: 2] = $urandom_range(0, 1) ? 2'b10 : 2'b01;
      end
      pin_en = 16'h7FFF;
      rs = '{default: 0};
      pv = '0;
      step(10);
      for (int w = 0; w < 3000; w++) begin
         step(1);
         cv = {stage_clk, port_p, port_n, port0, port10};
         for (int b = 0; b < 22; b++) begin
            rs[b] += int'(cv[b] && !pv[b]);
         end
         pv = cv;
         for (int p = 0; p < 7; p++) begin
            if (port_p[p] === port_n[p]) rs[0] += 1000;
         end
      end
      for (int p = 0; p < 8; p++) begin
         chk("div_rate", 1'((rs[18 + port_src[2*p +: 2]] / n[p] - rs[10 + p])
             inside {[-2:2]}), 1'b1);
      end
      chk("pin_off", rs[9], 0);
      chk("port0", 1'((rs[19] - rs[1]) inside {[-2:2]}), 1'b1);
      chk("port10", 1'((rs[21] - rs[0]) inside {[-2:2]}), 1'b1);
      $display("test dividers done");
      // Port 0 is forced off so the powered-down path is always seen.
      port_fmt = {8'hE4, 8'($urandom) | 8'h03};
      step(3);
      chk("tx_fmt", tx_fmt, port_fmt);
      for (int p = 0; p < 8; p++) begin
         chk("tx_pwr", tx_pwr[p], port_fmt[2*p +: 2] != 2'b11);
      end
      // Differential formats drive complementary pins; off drives none.
      repeat (20) begin
         step(1);
         for (int p = 0; p < 8; p++) begin
            if (port_fmt[2*p +: 2] == 2'b11)
               chk("pins_off", {port_p[p], port_n[p]}, 2'b00);
            else if (port_fmt[2*p +: 2] != 2'b00)
               chk("pins_diff", port_p[p] ^ port_n[p], 1'b1);
         end
      end
      mv = '{14'd0, 14'd1249, 14'd1250, 14'd5000, 14'd10000, 14'd10001,
             14'($urandom)};
      foreach (mv[k]) begin
         synth_m = mv[k];
         step(3);
         chk("synth_m", synth_q, clamp(mv[k]));
      end
      $display("test formats and synth done");
      wr(ADDR_PPS_LO, 8'h03);
      wr(ADDR_PPS_HI, 8'h00);
      rd("width_rd", ADDR_PPS_LO, 8'h03);
      step(1);
      pps_tick = 1'b1;
      step(1);
      pps_tick = 1'b0;
      n[0] = 0;
      while (pps === 1'b1 && n[0] < 1000) begin
         n[0]++;
         step(1);
      end
      chk("pps_width", n[0], 3 * CYC_PER_US);
      $display("test pulse done");
      conclude();
   end
endmodule : test_pcoc_top
`default_nettype wire
